// *** hw/pmp_master.sv ***
// Purpose: parallel master bus port driving external memories and peripherals
// Assumes: plain software ports, split pins
// Notes: read data is from the previous bus read
// Summary of operation
// - both selects active when address 15,14 set
// - mode 11 style one, 10 style two
// - byte width default, wide uses sixteen pins
// - chip select pins excluded from address stepping
// - select function: none, upper only, both
// - mask bit one makes pin address line
// - style one: direction line plus enable
// - style two: separate read and write strobes
// - strobe pins driven only when enabled
// - per-signal polarity, one means active high
// - shared pin shares one polarity bit
// - address steps after transfer completes
// - address-serving select bits do step
// - begin, middle, end wait counts stretch cycles
// - two-bit field picks multiplex scheme
// - multiplexed schemes add address phase cycles
// - demultiplexed: address on address pins
// - partial: low address on data byte
// - full byte: whole address on data byte
// - select bits forced zero in multiplexed address
// - busy drops one cycle before end
// - read returns old value, starts bus read
// - off bit holds port idle and undriven
`timescale 1ns/1ns
module pmp_master
    import pmp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic ON,
    input wire logic [1:0] MODE,
    input wire logic WIDE_DATA_SEL,
    input wire logic [1:0] SELECT_FUNCTION,
    input wire logic [15:0] PIN_ENABLE_MASK,
    input wire logic READ_PIN_EN,
    input wire logic WRITE_PIN_EN,
    input wire logic READ_POLARITY,
    input wire logic WRITE_POLARITY,
    input wire logic SELECT_HIGH_POLARITY,
    input wire logic SELECT_LOW_POLARITY,
    input wire logic LATCH_POLARITY,
    input wire logic [1:0] ADDRESS_STEP,
    input wire logic [1:0] WAIT_BEGIN,
    input wire logic [3:0] WAIT_MIDDLE,
    input wire logic [1:0] WAIT_END,
    input wire logic [1:0] MUX_SCHEME,
    input wire logic ADDR_WR,
    input wire logic [15:0] ADDR_WDATA,
    output logic [15:0] ADDRESS,
    input wire logic WR_VALID,
    output logic WR_READY,
    input wire logic [15:0] WR_DATA,
    input wire logic RD_REQ,
    output logic [15:0] RD_DATA,
    output logic BUSY,
    output logic [15:0] ADDR_PINS_O,
    output logic [15:0] ADDR_PINS_OE,
    output logic [15:0] DATA_PINS_O,
    output logic [15:0] DATA_PINS_OE,
    input wire logic [15:0] DATA_PINS_I,
    output logic READ_STROBE_O,
    output logic READ_STROBE_OE,
    output logic WRITE_STROBE_O,
    output logic WRITE_STROBE_OE
);
    state_t state; // sequencer state
    state_t next_state; // sequencer next state
    logic [3:0] cnt; // wait counter within a phase
    logic [3:0] next_cnt; // counter next value
    logic is_write; // current transfer is a write
    logic [15:0] wdata; // data held for the bus write
    logic [15:0] data_sync; // synchronised data pins
    logic [15:0] buf_data; // head of the write buffer
    logic buf_valid; // write waiting in buffer
    logic [15:0] next_addr_o; // address pin values
    logic [15:0] next_addr_oe; // address pin enables
    logic [15:0] next_data_o; // data pin values
    logic [15:0] next_data_oe; // data pin enables

    // configuration decode
    wire master_on = ON && (MODE == MODE_STYLE_ONE || MODE == MODE_STYLE_TWO);
    wire style_one = (MODE == MODE_STYLE_ONE);
    wire sel_hi_en = (SELECT_FUNCTION == SEL_HIGH_ONLY) || (SELECT_FUNCTION == SEL_BOTH);
    wire sel_lo_en = (SELECT_FUNCTION == SEL_BOTH); // lower alone impossible
    wire muxed = (MUX_SCHEME != MUX_DEMUX);
    wire [15:0] lane_mask = WIDE_DATA_SEL ? MASK_ALL : MASK_LOW_BYTE;

    // request decode
    wire idle = (state == ST_IDLE);
    wire take_write = master_on && idle && buf_valid;
    wire take_read = master_on && idle && !buf_valid && RD_REQ;
    wire start = take_write || take_read;
    wire last_cycle = (state == ST_END) && (cnt == CNT_ZERO);

    // address stepping, select pins kept out of the carry
    wire [15:0] step_mask = {!sel_hi_en, !sel_lo_en, 14'h3fff};
    wire [15:0] addr_inc = ADDRESS + ADDR_ONE;
    wire [15:0] addr_dec = ADDRESS - ADDR_ONE;
    wire [15:0] addr_moved = (ADDRESS & ~step_mask) |
                             (((ADDRESS_STEP == STEP_INC) ? addr_inc : addr_dec) & step_mask);
    wire do_step = last_cycle && (ADDRESS_STEP == STEP_INC || ADDRESS_STEP == STEP_DEC);

    // address on shared pins, select bits forced low
    wire [15:0] mux_addr = {ADDRESS[15] && !sel_hi_en, ADDRESS[14] && !sel_lo_en,
                            ADDRESS[13:0]};

    // phase flags
    wire in_op = !idle;
    wire in_mid = (state == ST_MIDDLE);
    wire in_data = (state == ST_BEGIN) || in_mid || (state == ST_END);
    wire latch_lo_act = (state == ST_ALO);
    wire latch_hi_act = (state == ST_AHI) ||
                        ((state == ST_ALO) && (MUX_SCHEME == MUX_FULL16));
    wire latch_lo_lvl = latch_lo_act ? LATCH_POLARITY : !LATCH_POLARITY;
    wire latch_hi_lvl = latch_hi_act ? LATCH_POLARITY : !LATCH_POLARITY;
    wire sel_hi_lvl = (in_op && ADDRESS[15]) ? SELECT_HIGH_POLARITY
                                              : !SELECT_HIGH_POLARITY;
    wire sel_lo_lvl = (in_op && ADDRESS[14]) ? SELECT_LOW_POLARITY
                                              : !SELECT_LOW_POLARITY;

    // strobe levels per style
    wire rd_act = style_one ? (in_op && !is_write) : (in_mid && !is_write);
    wire wr_act = style_one ? in_mid : (in_mid && is_write);
    wire next_rd_o = rd_act ? READ_POLARITY : !READ_POLARITY;
    wire next_wr_o = wr_act ? WRITE_POLARITY : !WRITE_POLARITY;

    // busy low on the final cycle of a transfer
    wire next_last = (next_state == ST_END) && (next_cnt == CNT_ZERO);
    wire next_busy = (next_state != ST_IDLE) && !next_last;

    // write buffer between software and the sequencer
    pmp_buf2 #(
        .WIDTH(DATA_W)
    ) u_wbuf (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(WR_VALID),
        .in_ready(WR_READY),
        .in_data(WR_DATA),
        .out_valid(buf_valid),
        .out_ready(take_write),
        .out_data(buf_data)
    );

    // data pins pass two flops before use
    pmp_sync #(
        .WIDTH(DATA_W)
    ) u_dsync (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(DATA_PINS_I),
        .sync_out(data_sync)
    );

    // sequencer next state
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = muxed ? ST_ALO : ST_BEGIN;
                    next_cnt = muxed ? CNT_ZERO : {2'h0, WAIT_BEGIN};
                end
            end
            ST_ALO: begin
                // byte-wide full scheme needs a second address phase
                next_state = (MUX_SCHEME == MUX_FULL8) ? ST_AHI : ST_BEGIN;
                next_cnt = (MUX_SCHEME == MUX_FULL8) ? CNT_ZERO : {2'h0, WAIT_BEGIN};
            end
            ST_AHI: begin
                next_state = ST_BEGIN;
                next_cnt = {2'h0, WAIT_BEGIN};
            end
            ST_BEGIN: begin
                if (cnt == CNT_ZERO) begin
                    next_state = ST_MIDDLE;
                    next_cnt = WAIT_MIDDLE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_MIDDLE: begin
                if (cnt == CNT_ZERO) begin
                    next_state = ST_END;
                    next_cnt = {2'h0, WAIT_END};
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_END: begin
                if (cnt == CNT_ZERO) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt = CNT_ZERO;
            end
        endcase
        if (!master_on) begin
            // module off: abandon any transfer
            next_state = ST_IDLE;
            next_cnt = CNT_ZERO;
        end
    end

    // address pin drive per scheme
    always_comb begin
        next_addr_o = ZERO16;
        next_addr_oe = PIN_ENABLE_MASK & {16{master_on}};
        case (MUX_SCHEME)
            MUX_DEMUX: begin
                next_addr_o = ADDRESS;
            end
            MUX_PARTIAL: begin
                next_addr_o[15:8] = ADDRESS[15:8];
                next_addr_o[PIN_LATCH_LO] = latch_lo_lvl;
                next_addr_oe[7:1] = 7'h00; // freed pins
            end
            default: begin
                next_addr_o[PIN_LATCH_LO] = latch_lo_lvl;
                next_addr_o[PIN_LATCH_HI] = latch_hi_lvl;
                next_addr_oe[13:2] = 12'h000; // freed pins
                next_addr_oe[15] = next_addr_oe[15] && sel_hi_en; // pins 15,14 remain only as selects
                next_addr_oe[14] = next_addr_oe[14] && sel_lo_en;
            end
        endcase
        if (sel_hi_en) begin
            next_addr_o[PIN_SEL_HI] = sel_hi_lvl;
        end
        if (sel_lo_en) begin
            next_addr_o[PIN_SEL_LO] = sel_lo_lvl;
        end
    end

    // data pin drive: address phases, then write data
    always_comb begin
        next_data_o = ZERO16;
        next_data_oe = ZERO16;
        if (master_on) begin
            case (state)
                ST_ALO: begin
                    if (MUX_SCHEME == MUX_FULL16) begin
                        next_data_o = mux_addr;
                        next_data_oe = MASK_ALL;
                    end else begin
                        next_data_o[7:0] = mux_addr[7:0];
                        next_data_oe = MASK_LOW_BYTE;
                    end
                end
                ST_AHI: begin
                    next_data_o[7:0] = mux_addr[15:8];
                    next_data_oe = MASK_LOW_BYTE;
                end
                default: begin
                    if (in_data && is_write) begin
                        next_data_o = wdata & lane_mask;
                        next_data_oe = lane_mask;
                    end
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            cnt <= CNT_ZERO;
            BUSY <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            BUSY <= next_busy;
        end
    end

    // transfer kind and write data capture
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            is_write <= 1'b0;
            wdata <= ZERO16;
        end else if (start) begin
            is_write <= take_write;
            wdata <= take_write ? buf_data : wdata;
        end
    end

    // address register: software load wins over stepping
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ADDRESS <= ZERO16;
        end else if (ADDR_WR) begin
            ADDRESS <= ADDR_WDATA;
        end else if (do_step) begin
            ADDRESS <= addr_moved;
        end
    end

    // read data latched at close of middle phase
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RD_DATA <= ZERO16;
        end else if (in_mid && cnt == CNT_ZERO && !is_write) begin
            RD_DATA <= data_sync & lane_mask;
        end
    end

    // registered pin outputs
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ADDR_PINS_O <= ZERO16;
            ADDR_PINS_OE <= ZERO16;
            DATA_PINS_O <= ZERO16;
            DATA_PINS_OE <= ZERO16;
            READ_STROBE_O <= 1'b0;
            READ_STROBE_OE <= 1'b0;
            WRITE_STROBE_O <= 1'b0;
            WRITE_STROBE_OE <= 1'b0;
        end else begin
            ADDR_PINS_O <= next_addr_o;
            ADDR_PINS_OE <= next_addr_oe;
            DATA_PINS_O <= next_data_o;
            DATA_PINS_OE <= next_data_oe;
            READ_STROBE_O <= next_rd_o;
            READ_STROBE_OE <= READ_PIN_EN && master_on;
            WRITE_STROBE_O <= next_wr_o;
            WRITE_STROBE_OE <= WRITE_PIN_EN && master_on;
        end
    end
endmodule

// *** hw/pmp_pkg.sv ***
// Purpose: shared constants and types of the parallel master bus port
// Assumes: one clock, config on plain ports
// Notes: field codes as seen on the config ports
package pmp_pkg;
    // bus widths
    localparam int ADDR_W = 16; // address pins
    localparam int DATA_W = 16; // data pins
    // strobe style codes
    localparam logic [1:0] MODE_STYLE_ONE = 2'h3; // rw line plus enable
    localparam logic [1:0] MODE_STYLE_TWO = 2'h2; // separate read and write
    // chip select function codes
    localparam logic [1:0] SEL_NONE = 2'h0; // both pins are address
    localparam logic [1:0] SEL_HIGH_ONLY = 2'h1; // upper select only
    localparam logic [1:0] SEL_BOTH = 2'h2; // both selects
    // address step codes
    localparam logic [1:0] STEP_NONE = 2'h0; // address kept
    localparam logic [1:0] STEP_INC = 2'h1; // add one
    localparam logic [1:0] STEP_DEC = 2'h2; // subtract one
    // multiplex scheme codes
    localparam logic [1:0] MUX_DEMUX = 2'h0; // separate address pins
    localparam logic [1:0] MUX_PARTIAL = 2'h1; // low address on low data byte
    localparam logic [1:0] MUX_FULL8 = 2'h2; // full address on low data byte
    localparam logic [1:0] MUX_FULL16 = 2'h3; // full address on all data pins
    // pin positions on the address pins
    localparam int PIN_LATCH_LO = 0; // low latch strobe
    localparam int PIN_LATCH_HI = 1; // high latch strobe
    localparam int PIN_SEL_LO = 14; // lower chip select
    localparam int PIN_SEL_HI = 15; // upper chip select
    // masks
    localparam logic [15:0] MASK_LOW_BYTE = 16'h00ff; // byte-wide lanes
    localparam logic [15:0] MASK_ALL = 16'hffff; // all lanes
    localparam logic [15:0] ADDR_ONE = 16'h0001; // step amount
    localparam logic [15:0] ZERO16 = 16'h0000; // reset value
    localparam logic [3:0] CNT_ZERO = 4'h0; // counter floor
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ALO,
        ST_AHI,
        ST_BEGIN,
        ST_MIDDLE,
        ST_END
    } state_t;
endpackage

// *** hw/pmp_sync.sv ***
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to CLK
// Notes: the first stage feeds only the second
`timescale 1ns/1ns
module pmp_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta; // first stage, read only by sync_out

    // two stage capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// *** hw/pmp_buf2.sv ***
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active low reset
// Notes: full lowers in_ready, stalling the source
`timescale 1ns/1ns
module pmp_buf2 #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot0; // head entry
    logic [WIDTH-1:0] slot1; // second entry
    logic [1:0] count; // entries held
    wire push = in_valid && in_ready; // accepted write
    wire pop = out_valid && out_ready; // drained word
    wire [1:0] next_count = count + {1'b0, push} - {1'b0, pop}; // occupancy after edge

    assign out_valid = (count != 2'h0); // honest empty
    assign out_data = slot0;

    // occupancy and storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 2'h0;
            in_ready <= 1'b1;
            slot0 <= '0;
            slot1 <= '0;
        end else begin
            count <= next_count;
            in_ready <= (next_count != 2'h2); // registered full
            if (pop) begin
                slot0 <= (count == 2'h2) ? slot1 : in_data; // shift or bypass
            end else if (push && count == 2'h0) begin
                slot0 <= in_data;
            end
            if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
                slot1 <= in_data;
            end
        end
    end
endmodule

// *** dv/pmp_master_props.sv ***
// Purpose: pin checks of the master port
// Assumes: one clock, RST_N sync low
// Notes: sees top ports only
`timescale 1ns/1ns
module pmp_master_props
    import pmp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic ON,
    input wire logic [1:0] MODE,
    input wire logic WIDE_DATA_SEL,
    input wire logic [1:0] SELECT_FUNCTION,
    input wire logic READ_PIN_EN,
    input wire logic WRITE_PIN_EN,
    input wire logic READ_POLARITY,
    input wire logic WRITE_POLARITY,
    input wire logic [1:0] ADDRESS_STEP,
    input wire logic [1:0] MUX_SCHEME,
    input wire logic ADDR_WR,
    input wire logic [15:0] ADDR_WDATA,
    input wire logic [15:0] ADDRESS,
    input wire logic BUSY,
    input wire logic [15:0] ADDR_PINS_OE,
    input wire logic [15:0] DATA_PINS_OE,
    input wire logic READ_STROBE_O,
    input wire logic READ_STROBE_OE,
    input wire logic WRITE_STROBE_O,
    input wire logic WRITE_STROBE_OE
);
    // any pin of the port driven
    wire any_oe = |{ADDR_PINS_OE, DATA_PINS_OE, READ_STROBE_OE, WRITE_STROBE_OE};
    // one of the two master codes
    wire master = (MODE == MODE_STYLE_ONE) || (MODE == MODE_STYLE_TWO);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // two idle cycles with settings unchanged
    sequence s_quiet;
        !BUSY && $past(!BUSY) && $past(RST_N)
            && $stable({ON, MODE, READ_PIN_EN, WRITE_PIN_EN, READ_POLARITY, WRITE_POLARITY});
    endsequence
    // read pin live, style two
    sequence s_rd_live;
        ON && READ_PIN_EN && (MODE == MODE_STYLE_TWO);
    endsequence
    a_off_undriven: assert property ($past(!ON) |-> !any_oe)
        else $error("pins driven while port off");
    a_mode_off: assert property ($past(!master) |-> !any_oe)
        else $error("pins driven with no master code");
    a_byte_lanes: assert property ($past(!WIDE_DATA_SEL && MUX_SCHEME != MUX_FULL16)
        |-> DATA_PINS_OE[15:8] == 8'h00)
        else $error("upper data lanes driven in byte width");
    a_read_pin_off: assert property ($past(!READ_PIN_EN) |-> !READ_STROBE_OE)
        else $error("read strobe pin driven while disabled");
    a_write_pin_off: assert property ($past(!WRITE_PIN_EN) |-> !WRITE_STROBE_OE)
        else $error("write strobe pin driven while disabled");
    a_read_idle_level: assert property (s_rd_live ##0 s_quiet
        |-> READ_STROBE_O == !READ_POLARITY)
        else $error("read strobe not at idle level");
    a_write_idle_level: assert property ((ON && WRITE_PIN_EN && MODE[1]) ##0 s_quiet
        |-> WRITE_STROBE_O == !WRITE_POLARITY)
        else $error("write strobe not at idle level");
    a_busy_gap: assert property ($fell(BUSY) |=> !BUSY)
        else $error("busy back high right after falling");
    a_select_kept: assert property ($past(RST_N && SELECT_FUNCTION == SEL_BOTH && !ADDR_WR)
        |-> ADDRESS[15:14] == $past(ADDRESS[15:14]))
        else $error("select bits stepped");
    a_step_none: assert property ($past(RST_N && ADDRESS_STEP == STEP_NONE && !ADDR_WR)
        |-> $stable(ADDRESS))
        else $error("address moved with stepping off");
    a_addr_load: assert property ($past(RST_N && ADDR_WR) |-> ADDRESS == $past(ADDR_WDATA))
        else $error("address load lost");
endmodule
bind pmp_master pmp_master_props u_props (.*);

// *** dv/pmp_ext_mem.sv ***
// Purpose: memory model behind the port
// Assumes: style two, address on low pins
// Notes: idle bus reads back inverted
`timescale 1ns/1ns
module pmp_ext_mem (
    input wire logic clk,
    input wire logic [3:0] lat,
    input wire logic rd_pol,
    input wire logic wr_pol,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] addr,
    input wire logic [15:0] data_o,
    output logic [15:0] data_i
);
    logic [15:0] mem [256]; // word store
    logic [3:0] age = 4'h0; // read strobe age
    wire rd_on = (rd_strobe == rd_pol); // read strobe active
    wire wr_on = (wr_strobe == wr_pol); // write strobe active
    initial begin
        data_i = 16'h5a5a;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
    end
    // capture writes, answer reads after lat cycles
    always @(posedge clk) begin
        if (wr_on) begin
            mem[addr] <= data_o;
        end
        age <= rd_on ? age + 4'h1 : 4'h0;
        if (rd_on && age >= lat) begin
            data_i <= mem[addr];
        end else begin
            data_i <= ~data_i; // released bus
        end
    end
endmodule

// *** dv/pmp_master_tb.sv ***
// Purpose: bench for the master port
// Assumes: 10 MHz clock, demux style two data
// Notes: expectations from the rules
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end
module pmp_master_tb
    import pmp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic on = 1'b0, wide = 1'b1, rd_en = 1'b1, wr_en = 1'b1, rd_pol = 1'b0, wr_pol = 1'b0;
    logic hi_pol = 1'b0, lo_pol = 1'b0, al_pol = 1'b1, addr_wr = 1'b0, wr_valid = 1'b0;
    logic rd_req = 1'b0;
    logic [1:0] mode = MODE_STYLE_TWO, sel_fn = SEL_NONE, step = STEP_INC;
    logic [1:0] wb = 2'h0, we = 2'h0, mux = MUX_DEMUX;
    logic [3:0] wm = 4'h8, lat = 4'h2;
    logic [15:0] mask = 16'hffff, addr_wdata = 16'h0000, wr_data = 16'h0000;
    logic [15:0] address, rd_data, ap_o, ap_oe, dp_o, dp_oe, dp_i, a, d, old;
    logic wr_ready, busy, rs_o, rs_oe, ws_o, ws_oe;
    logic [15:0] wd [6]; // words written in the first pass
    int fail_count = 0, comparisons = 0, c;
    integer seed = 32'hb7ecede3;
    // select fn, step, start, expected address
    localparam logic [1:0] SFS [4] = '{SEL_NONE, SEL_HIGH_ONLY, SEL_BOTH, SEL_BOTH};
    localparam logic [1:0] STP [4] = '{STEP_INC, STEP_INC, STEP_INC, STEP_DEC};
    localparam logic [15:0] SA [4] = '{16'hffff, 16'hbfff, 16'hffff, 16'hc000};
    localparam logic [15:0] SE [4] = '{16'h0000, 16'hc000, 16'hc000, 16'hffff};

    pmp_master DUT (.CLK(clk), .RST_N(rst_n), .ON(on), .MODE(mode), .WIDE_DATA_SEL(wide),
        .SELECT_FUNCTION(sel_fn), .PIN_ENABLE_MASK(mask), .READ_PIN_EN(rd_en),
        .WRITE_PIN_EN(wr_en), .READ_POLARITY(rd_pol), .WRITE_POLARITY(wr_pol),
        .SELECT_HIGH_POLARITY(hi_pol), .SELECT_LOW_POLARITY(lo_pol), .LATCH_POLARITY(al_pol),
        .ADDRESS_STEP(step), .WAIT_BEGIN(wb), .WAIT_MIDDLE(wm), .WAIT_END(we), .MUX_SCHEME(mux),
        .ADDR_WR(addr_wr), .ADDR_WDATA(addr_wdata), .ADDRESS(address), .WR_VALID(wr_valid),
        .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_REQ(rd_req), .RD_DATA(rd_data),
        .BUSY(busy), .ADDR_PINS_O(ap_o), .ADDR_PINS_OE(ap_oe), .DATA_PINS_O(dp_o),
        .DATA_PINS_OE(dp_oe), .DATA_PINS_I(dp_i), .READ_STROBE_O(rs_o),
        .READ_STROBE_OE(rs_oe), .WRITE_STROBE_O(ws_o), .WRITE_STROBE_OE(ws_oe));
    pmp_ext_mem MEM (.clk(clk), .lat(lat), .rd_pol(rd_pol), .wr_pol(wr_pol), .rd_strobe(rs_o),
        .wr_strobe(ws_o), .addr(ap_o[7:0]), .data_o(dp_o), .data_i(dp_i));

    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end
    // verdict and end of run
    task automatic results;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // step just past the rising edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    // load the current address
    task automatic load(input logic [15:0] v);
        addr_wdata = v;
        addr_wr = 1'b1;
        tick;
        addr_wr = 1'b0;
    endtask
    // offer one word until taken
    task automatic put(input logic [15:0] v);
        int n;
        n = 0;
        wr_data = v;
        wr_valid = 1'b1;
        while (wr_ready !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        if (n == 100) begin
            fail_count++;
            results;
        end
        tick;
    endtask
    // wait out the operation
    task automatic idle;
        int n;
        n = 0;
        wr_valid = 1'b0;
        repeat (3) tick;
        while (busy !== 1'b0 && n < 300) begin
            tick;
            n++;
        end
        if (n == 300) begin
            fail_count++;
            results;
        end
        repeat (2) tick;
    endtask
    // count cycles with busy high
    task automatic span(output int cnt);
        int n;
        n = 0;
        cnt = 0;
        wr_valid = 1'b0;
        while (busy !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        while (busy === 1'b1 && cnt < 300) begin
            tick;
            cnt++;
        end
    endtask
    // busy cycles: phases, waits, minus early drop
    function automatic int span_exp(input logic [1:0] m, input logic [1:0] b,
            input logic [3:0] md, input logic [1:0] e);
        return int'(m != MUX_DEMUX) + int'(m == MUX_FULL8) + int'(b) + int'(md) + int'(e) + 2;
    endfunction
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        results;
    end
    // main sequence
    initial begin
        repeat (6) tick;
        `CHK({address, rd_data, ap_oe, dp_oe, busy}, 65'h0)
        rst_n = 1'b1;
        on = 1'b1;
        tick;
        // random writes
        a = 16'h0010;
        load(a);
        for (int i = 0; i < 6; i++) begin
            {rd_pol, wr_pol} = 2'($random(seed));
            wd[i] = 16'($random(seed));
            put(wd[i]);
            idle;
            `CHK(MEM.mem[a[7:0]], wd[i])
            a = a + 16'h0001;
            `CHK(address, a)
        end
        // reads hand back the old word first
        step = STEP_NONE;
        for (int i = 0; i < 2; i++) begin
            a = 16'h0010 + 16'(i);
            load(a);
            old = rd_data;
            rd_req = 1'b1;
            tick;
            rd_req = 1'b0;
            `CHK(rd_data, old)
            idle;
            `CHK(rd_data, wd[i])
            `CHK(address, a)
        end
        // stepping around the select bits
        for (int k = 0; k < 4; k++) begin
            sel_fn = SFS[k];
            step = STP[k];
            load(SA[k]);
            put(16'($random(seed)));
            idle;
            `CHK(address, SE[k])
        end
        // cycle length per scheme
        sel_fn = SEL_NONE;
        step = STEP_NONE;
        for (int k = 0; k < 8; k++) begin
            mux = k[1:0];
            mode = k[2] ? MODE_STYLE_ONE : MODE_STYLE_TWO;
            {wb, we, wm, hi_pol, lo_pol, al_pol} = 11'($random(seed));
            put(16'($random(seed)));
            span(c);
            `CHK(c, span_exp(mux, wb, wm, we))
            idle;
        end
        // byte width write
        mux = MUX_DEMUX;
        mode = MODE_STYLE_TWO;
        wide = 1'b0;
        load(16'h0033);
        d = 16'($random(seed));
        put(d);
        idle;
        `CHK(MEM.mem[8'h33][7:0], d[7:0])
        `CHK(dp_oe[15:8], 8'h00)
        // buffer fills while off
        wide = 1'b1;
        step = STEP_INC;
        load(16'h0040);
        on = 1'b0;
        d = 16'($random(seed));
        put(d);
        put(~d);
        wr_valid = 1'b0;
        tick;
        `CHK(wr_ready, 1'b0)
        `CHK(busy, 1'b0)
        on = 1'b1;
        idle;
        idle;
        `CHK(MEM.mem[8'h40], d)
        `CHK(MEM.mem[8'h41], ~d)
        `CHK(address, 16'h0042)
        // non-master codes stay idle
        rd_en = 1'b0;
        wr_en = 1'b0;
        for (int k = 0; k < 2; k++) begin
            mode = 2'(k);
            rd_req = 1'b1;
            tick;
            rd_req = 1'b0;
            repeat (2) tick;
            `CHK(busy, 1'b0)
            `CHK(rs_oe | ws_oe, 1'b0)
        end
        results;
    end
endmodule
